//--- logic/dird_pkg.sv
package dird_pkg;
    // Register offsets
    localparam logic [6:0] ADDR_RX_FMT_OSR = 7'h0C;
    localparam logic [6:0] ADDR_DAC_ROUTING = 7'h0F;
    localparam logic [6:0] ADDR_DAC_MIX_ZF = 7'h10;
    // Reset values
    localparam logic [7:0] RST_RX_FMT_OSR = 8'h0A;
    localparam logic [7:0] RST_DAC_ROUTING = 8'hE4;
    localparam logic [7:0] RST_DAC_MIX_ZF = 8'h09;
    // Field positions in rx_format_and_oversampling
    localparam int FMT_LSB = 0;
    localparam int WL_LSB = 2;
    localparam int LRP_BIT = 4;
    localparam int BCP_BIT = 5;
    localparam int OSR_BIT = 6;
    // Field positions in dac_mix_and_zero_flag
    localparam int MIX_LSB = 0;
    localparam int ZERO_FLAG_SOURCE_SELECT_LSB = 4;
    localparam int IZD_BIT = 7;
    // Interface formats
    typedef enum logic [1:0] {
        FMT_RJ = 2'h0,
        FMT_LJ = 2'h1,
        FMT_I2S = 2'h2,
        FMT_DSP = 2'h3
    } dird_fmt_e;
    // Word length codes
    typedef enum logic [1:0] {
        WL_16 = 2'h0,
        WL_20 = 2'h1,
        WL_24 = 2'h2,
        WL_32 = 2'h3
    } dird_wl_e;
    // Sizes and counts
    localparam int SAMPLE_W = 24;
    localparam int NUM_DAC = 4;
    localparam logic [10:0] ZERO_RUN = 11'h400;
    localparam logic [7:0] AUTO16_PERIOD = 8'h20;
    localparam logic [3:0] MIX_ALL_MUTE = 4'h0;
    localparam logic [3:0] MIX_STRAIGHT = 4'h9;
endpackage : dird_pkg

//--- logic/dird_async_fifo.sv
`timescale 1ns/1ns
module dird_async_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 8
) (
    // Write side
    input wire logic wr_clk_i,
    input wire logic wr_rst_n_i,
    input wire logic [W-1:0] wr_data_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    // Read side
    input wire logic rd_clk_i,
    input wire logic rd_rst_n_i,
    output logic [W-1:0] rd_data_o,
    output logic rd_valid_o,
    input wire logic rd_ready_i
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH]; // Flop storage
    logic [AW:0] wbin, wgray, rbin, rgray;
    logic [AW:0] wg_s1, wg_s2, rg_s1, rg_s2; // Gray pointer syncs
    wire logic push = wr_valid_i && wr_ready_o;
    wire logic pop = rd_valid_o && rd_ready_i;
    wire logic [AW:0] next_wbin = wbin + {{AW{1'b0}}, push};
    wire logic [AW:0] next_rbin = rbin + {{AW{1'b0}}, pop};
    // Full when the write pointer laps the synced read pointer
    assign wr_ready_o = wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]};
    assign rd_valid_o = rgray != wg_s2;
    assign rd_data_o = mem[rbin[AW-1:0]];

    // Storage write, no reset needed
    always_ff @(posedge wr_clk_i) begin
        if (push) begin
            mem[wbin[AW-1:0]] <= wr_data_i;
        end
    end

    // Write pointer and read pointer sync
    always_ff @(posedge wr_clk_i) begin
        if (!wr_rst_n_i) begin
            wbin <= '0;
            wgray <= '0;
            rg_s1 <= '0;
            rg_s2 <= '0;
        end else begin
            wbin <= next_wbin;
            wgray <= next_wbin ^ (next_wbin >> 1);
            rg_s1 <= rgray;
            rg_s2 <= rg_s1;
        end
    end

    // Read pointer and write pointer sync
    always_ff @(posedge rd_clk_i) begin
        if (!rd_rst_n_i) begin
            rbin <= '0;
            rgray <= '0;
            wg_s1 <= '0;
            wg_s2 <= '0;
        end else begin
            rbin <= next_rbin;
            rgray <= next_rbin ^ (next_rbin >> 1);
            wg_s1 <= wgray;
            wg_s2 <= wg_s1;
        end
    end
endmodule : dird_async_fifo

//--- logic/dird_link_rx.sv
`timescale 1ns/1ns
module dird_link_rx #(
    parameter int SW = 24,
    parameter int NIN = 4
) (
    // Link clock, polarity already applied
    input wire logic link_clk_i,
    input wire logic rst_n_i,
    // Format levels from the register domain
    input wire logic [1:0] fmt_i,
    input wire logic [1:0] wl_i,
    input wire logic lrp_i,
    // Serial pins
    input wire logic lrclk_i,
    input wire logic [NIN-1:0] sdata_i,
    // Frame towards the FIFO
    output logic [2*SW*NIN-1:0] frame_o,
    output logic frame_valid_o,
    input wire logic frame_ready_i
);
    logic [1:0] rst_s; // Reset sync
    logic [4:0] cfg_s1, cfg_s2; // Config syncs
    logic lr_q; // Slot side of the newest bit
    logic [5:0] bitcnt; // Bits in the current slot
    logic [7:0] percnt, period; // Bits per full frame
    wire logic rst_n = rst_s[1];
    wire logic [1:0] fmt = cfg_s2[1:0];
    wire logic [1:0] wl = cfg_s2[3:2];
    wire logic lr = lrclk_i ^ cfg_s2[4];
    wire logic i2s = fmt == dird_pkg::FMT_I2S;
    wire logic auto16 = period == dird_pkg::AUTO16_PERIOD;
    wire logic rj32 = fmt == dird_pkg::FMT_RJ && wl == dird_pkg::WL_32;
    wire logic [1:0] weff = auto16 ? dird_pkg::WL_16 : rj32 ? dird_pkg::WL_24 : wl;
    wire logic [5:0] wbits = weff == dird_pkg::WL_16 ? 6'h10 : weff == dird_pkg::WL_20 ? 6'h14
                           : weff == dird_pkg::WL_24 ? 6'h18 : 6'h20;
    // Capture at word end; right justified words end at the side change
    wire logic cap = fmt == dird_pkg::FMT_RJ ? lr != lr_q : bitcnt == wbits + {5'h0, i2s};
    wire logic left_q = i2s ? !lr_q : lr_q;
    wire logic [2*SW*NIN-1:0] cur_frame;
    wire logic load = cap && !left_q && (!frame_valid_o || frame_ready_i);

    // Synchronisers for reset and quasi-static format
    always_ff @(posedge link_clk_i) begin
        rst_s <= {rst_s[0], rst_n_i};
        cfg_s1 <= {lrp_i, wl_i, fmt_i};
        cfg_s2 <= cfg_s1;
    end

    // Slot and frame bit counting
    always_ff @(posedge link_clk_i) begin
        if (!rst_n) begin
            lr_q <= 1'b0;
            bitcnt <= 6'h00;
            percnt <= 8'h00;
            period <= 8'h00;
        end else begin
            lr_q <= lr;
            bitcnt <= lr != lr_q ? 6'h01 : bitcnt + {5'h0, bitcnt != 6'h3F};
            percnt <= lr && !lr_q ? 8'h01 : percnt + {7'h0, percnt != 8'hFF};
            if (lr && !lr_q) begin
                period <= percnt;
            end
        end
    end

    genvar i;
    for (i = 0; i < NIN; i++) begin : g_in
        logic [31:0] shift; // Serial shifter
        logic [SW-1:0] left; // Held left sample
        logic [SW-1:0] aligned;
        // Short words get zero LSBs, long words lose their 8 LSBs, or their 8 MSBs when right justified
        assign aligned = weff == dird_pkg::WL_16 ? {shift[15:0], 8'h00}
                       : weff == dird_pkg::WL_20 ? {shift[19:0], 4'h0}
                       : weff == dird_pkg::WL_24 ? shift[23:0] : shift[31:8];
        assign cur_frame[2*SW*i +: SW] = left;
        assign cur_frame[2*SW*i+SW +: SW] = aligned;
        // Shift and hold the left word
        always_ff @(posedge link_clk_i) begin
            shift <= {shift[30:0], sdata_i[i]};
            if (!rst_n) begin
                left <= '0;
            end else if (cap && left_q) begin
                left <= aligned;
            end
        end
    end

    // Frame register; a frame arriving while one still waits is dropped
    always_ff @(posedge link_clk_i) begin
        if (!rst_n) begin
            frame_o <= '0;
            frame_valid_o <= 1'b0;
        end else if (load) begin
            frame_o <= cur_frame;
            frame_valid_o <= 1'b1;
        end else if (frame_ready_i) begin
            frame_valid_o <= 1'b0;
        end
    end
endmodule : dird_link_rx

//--- logic/dird_dac_input_ctrl.sv
`timescale 1ns/1ns
module dird_dac_input_ctrl (
    // Clock and reset
    input wire logic REF_CLK_I,
    input wire logic RESET_N_I,
    // Serial audio link
    input wire logic BCLK_I,
    input wire logic LRCLK_I,
    input wire logic [3:0] SERIAL_INPUT_I,
    // Register port
    input wire logic REG_WR_I,
    input wire logic [6:0] REG_ADDR_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    // Per-converter controls
    input wire logic [3:0] CONV_POWER_DOWN_I,
    input wire logic [3:0] CONV_MUTE_BIT_I,
    // Converter feed
    output logic [191:0] DAC_DATA_O,
    output logic DAC_VALID_O,
    input wire logic DAC_READY_I,
    // Status
    output logic OSR_64X_O,
    output logic ZERO_FLAG_O
);
    localparam int SW = dird_pkg::SAMPLE_W;
    localparam int ND = dird_pkg::NUM_DAC;
    localparam int FW = 2 * SW * ND; // One stereo frame for all inputs

    // Software registers
    logic [7:0] reg_fmt_osr; // Format, word length, polarity, rate
    logic [7:0] reg_route; // Input select per converter
    logic [7:0] reg_mix_zf; // Mix, flag source, automute

    // Register write decode
    wire logic wr_fmt = REG_WR_I && REG_ADDR_I == dird_pkg::ADDR_RX_FMT_OSR;
    wire logic wr_route = REG_WR_I && REG_ADDR_I == dird_pkg::ADDR_DAC_ROUTING;
    wire logic wr_mix = REG_WR_I && REG_ADDR_I == dird_pkg::ADDR_DAC_MIX_ZF;

    // Read selection; unmapped addresses read zero
    wire logic [7:0] rd_mux = REG_ADDR_I == dird_pkg::ADDR_RX_FMT_OSR ? reg_fmt_osr
                            : REG_ADDR_I == dird_pkg::ADDR_DAC_ROUTING ? reg_route
                            : REG_ADDR_I == dird_pkg::ADDR_DAC_MIX_ZF ? reg_mix_zf : 8'h00;

    // Field extraction
    wire logic [1:0] fmt = reg_fmt_osr[dird_pkg::FMT_LSB +: 2];
    wire logic [1:0] wl = reg_fmt_osr[dird_pkg::WL_LSB +: 2];
    wire logic lrp = reg_fmt_osr[dird_pkg::LRP_BIT];
    wire logic bcp = reg_fmt_osr[dird_pkg::BCP_BIT];
    wire logic osr = reg_fmt_osr[dird_pkg::OSR_BIT];
    wire logic [3:0] mix = reg_mix_zf[dird_pkg::MIX_LSB +: 4];
    wire logic [2:0] zero_flag_source_select = reg_mix_zf[dird_pkg::ZERO_FLAG_SOURCE_SELECT_LSB +: 3];
    wire logic zero_automute_enable = reg_mix_zf[dird_pkg::IZD_BIT];

    // Inverting the bit clock moves sampling to its falling edge.
    // Change it only while the link is idle: a swap can glitch the clock.
    wire logic link_clk = BCLK_I ^ bcp;

    // Link to register-domain crossing
    wire logic [FW-1:0] link_frame;
    wire logic link_valid;
    wire logic link_ready;
    wire logic [FW-1:0] fifo_data;
    wire logic fifo_valid;

    // Take a frame only when the output slot is free or being emptied
    wire logic pop = fifo_valid && (!DAC_VALID_O || DAC_READY_I);

    // Per-converter results
    wire logic [FW-1:0] next_dac_data;
    wire logic [ND-1:0] dac_flag;
    wire logic [2:0] zsel_idx = zero_flag_source_select - 3'h1;

    // Flag source: all converters, one of them, or forced low
    wire logic next_zero_flag = zero_flag_source_select == 3'h0 ? &dac_flag
                              : zero_flag_source_select <= 3'h4 ? dac_flag[zsel_idx[1:0]] : 1'b0;

    // Output selection for one side of a converter
    function automatic logic [SW-1:0] mix_pick(
        input logic [1:0] code,
        input logic [SW-1:0] l,
        input logic [SW-1:0] r,
        input logic [SW-1:0] avg
    );
        logic [SW-1:0] res;
        res = '0;
        case (code)
            2'h0: res = '0; // Mute
            2'h1: res = l; // Left input
            2'h2: res = r; // Right input
            default: res = avg; // Half the sum
        endcase
        return res;
    endfunction : mix_pick

    // Serial receiver on the link clock
    dird_link_rx #(
        .SW(SW),
        .NIN(ND)
    ) u_link (
        .link_clk_i(link_clk),
        .rst_n_i(RESET_N_I),
        .fmt_i(fmt),
        .wl_i(wl),
        .lrp_i(lrp),
        .lrclk_i(LRCLK_I),
        .sdata_i(SERIAL_INPUT_I),
        .frame_o(link_frame),
        .frame_valid_o(link_valid),
        .frame_ready_i(link_ready)
    );

    // Eight-frame buffer that also crosses the clock domains
    dird_async_fifo #(
        .W(FW),
        .DEPTH(8)
    ) u_fifo (
        .wr_clk_i(link_clk),
        .wr_rst_n_i(u_link.rst_n),
        .wr_data_i(link_frame),
        .wr_valid_i(link_valid),
        .wr_ready_o(link_ready),
        .rd_clk_i(REF_CLK_I),
        .rd_rst_n_i(RESET_N_I),
        .rd_data_o(fifo_data),
        .rd_valid_o(fifo_valid),
        .rd_ready_i(pop)
    );

    // Unpack the frame into per-input samples
    logic [SW-1:0] in_l [ND];
    logic [SW-1:0] in_r [ND];
    genvar i;
    for (i = 0; i < ND; i++) begin : g_unpack
        assign in_l[i] = fifo_data[2*SW*i +: SW];
        assign in_r[i] = fifo_data[2*SW*i+SW +: SW];
    end

    genvar d;
    for (d = 0; d < ND; d++) begin : g_dac
        logic [10:0] cnt_l, cnt_r; // Consecutive zero counts
        wire logic [1:0] sel = reg_route[2*d +: 2];
        wire logic [SW-1:0] rl = in_l[sel];
        wire logic [SW-1:0] rr = in_r[sel];
        // Sign-extend before adding so the average keeps its sign
        wire logic [SW:0] sum = {rl[SW-1], rl} + {rr[SW-1], rr};
        wire logic [SW-1:0] avg = sum[SW:1];
        // Counters saturate at the run length
        wire logic [10:0] next_cnt_l = rl != '0 ? 11'h000
                                     : cnt_l + {10'h0, cnt_l != dird_pkg::ZERO_RUN};
        wire logic [10:0] next_cnt_r = rr != '0 ? 11'h000
                                     : cnt_r + {10'h0, cnt_r != dird_pkg::ZERO_RUN};
        wire logic zl = cnt_l == dird_pkg::ZERO_RUN;
        wire logic zr = cnt_r == dird_pkg::ZERO_RUN;
        wire logic zl_n = next_cnt_l == dird_pkg::ZERO_RUN;
        wire logic zr_n = next_cnt_r == dird_pkg::ZERO_RUN;
        // Muting ends on the same sample that breaks the run
        wire logic amute = zero_automute_enable && zl_n && zr_n;
        wire logic [SW-1:0] out_l = amute ? '0 : mix_pick(mix[1:0], rl, rr, avg);
        wire logic [SW-1:0] out_r = amute ? '0 : mix_pick(mix[3:2], rl, rr, avg);
        assign next_dac_data[2*SW*d +: SW] = out_l;
        assign next_dac_data[2*SW*d+SW +: SW] = out_r;
        assign dac_flag[d] = (zl && zr) || CONV_POWER_DOWN_I[d] || CONV_MUTE_BIT_I[d];

        // Zero counters advance once per accepted frame
        always_ff @(posedge REF_CLK_I) begin
            if (!RESET_N_I) begin
                cnt_l <= 11'h000;
                cnt_r <= 11'h000;
            end else if (pop) begin
                cnt_l <= next_cnt_l;
                cnt_r <= next_cnt_r;
            end
        end
    end

    // Register writes
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            reg_fmt_osr <= dird_pkg::RST_RX_FMT_OSR;
            reg_route <= dird_pkg::RST_DAC_ROUTING;
            reg_mix_zf <= dird_pkg::RST_DAC_MIX_ZF;
        end else begin
            if (wr_fmt) begin
                reg_fmt_osr <= REG_WDATA_I;
            end
            if (wr_route) begin
                reg_route <= REG_WDATA_I;
            end
            if (wr_mix) begin
                reg_mix_zf <= REG_WDATA_I;
            end
        end
    end

    // Status outputs and read data
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            REG_RDATA_O <= 8'h00;
            OSR_64X_O <= 1'b0;
            ZERO_FLAG_O <= 1'b0;
        end else begin
            REG_RDATA_O <= rd_mux;
            OSR_64X_O <= osr;
            ZERO_FLAG_O <= next_zero_flag;
        end
    end

    // Output slot: holds a frame until the converter takes it
    always_ff @(posedge REF_CLK_I) begin
        if (!RESET_N_I) begin
            DAC_DATA_O <= '0;
            DAC_VALID_O <= 1'b0;
        end else if (pop) begin
            DAC_DATA_O <= next_dac_data;
            DAC_VALID_O <= 1'b1;
        end else if (DAC_READY_I) begin
            DAC_VALID_O <= 1'b0;
        end
    end

    // Checks on the register-clock side
    default clocking cb @(posedge REF_CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    AST_ROUTE_RESET: assert property (
        !$past(RESET_N_I) |-> reg_route == dird_pkg::RST_DAC_ROUTING)
        else $error("routing not at reset value");
    AST_OSR_WRITE: assert property (
        (REG_WR_I && REG_ADDR_I == dird_pkg::ADDR_RX_FMT_OSR)
        |-> ##2 OSR_64X_O == $past(REG_WDATA_I[dird_pkg::OSR_BIT], 2))
        else $error("oversampling output wrong");
    AST_ZERO_RUN: assert property (
        $rose(g_dac[0].zl) |-> $past(pop) && $past(g_dac[0].rl) == '0
        && $past(g_dac[0].cnt_l) == dird_pkg::ZERO_RUN - 11'h001)
        else $error("zero detect without full run");
    AST_ZERO_RESTART: assert property (
        (pop && g_dac[0].rl != '0) |=> g_dac[0].cnt_l == 11'h000 && !g_dac[0].zl)
        else $error("zero run not restarted");
    AST_FLAG_PD: assert property (
        (zero_flag_source_select == 3'h1 && CONV_POWER_DOWN_I[0]) |=> ZERO_FLAG_O)
        else $error("power-down did not raise flag");
    AST_FLAG_LOW: assert property (
        zero_flag_source_select >= 3'h5 |=> !ZERO_FLAG_O)
        else $error("flag not forced low");
    AST_ALL_FLAG: assert property (
        (zero_flag_source_select == 3'h0 && dac_flag != 4'hF) |=> !ZERO_FLAG_O)
        else $error("all flag set with one clear");
    AST_AUTOMUTE: assert property (
        (pop && zero_automute_enable && g_dac[0].zl_n && g_dac[0].zr_n) |=> DAC_DATA_O[47:0] == 48'h0)
        else $error("automute missing");
    AST_UNMUTE: assert property (
        (pop && zero_automute_enable && mix == dird_pkg::MIX_STRAIGHT && g_dac[0].rl != '0)
        |=> DAC_DATA_O[23:0] == $past(g_dac[0].rl))
        else $error("mute not released");
    AST_MIX_MUTE: assert property (
        (pop && mix == dird_pkg::MIX_ALL_MUTE) |=> DAC_DATA_O == '0)
        else $error("mute mix not silent");
    COV_POP: cover property (pop ##1 pop);
    COV_FLAG: cover property ($rose(ZERO_FLAG_O));
    COV_STALL: cover property (DAC_VALID_O && !DAC_READY_I [*3]);
endmodule : dird_dac_input_ctrl

//--- test/dird_audio_src.sv
`timescale 1ns/1ns
module dird_audio_src (
    // Serial link towards the device
    output logic bclk_o,
    output logic lrclk_o,
    output logic [3:0] sdata_o
);
    // Link clock stands still between frames
    initial begin
        bclk_o = 1'b0;
        lrclk_o = 1'b1;
        sdata_o = 4'h5;
    end

    // One bit clock: lines change while low, the device samples on the rise
    task automatic edge_out(input logic lr, input logic [3:0] d);
        lrclk_o = lr;
        sdata_o = d;
        #16 bclk_o = 1'b1;
        #16 bclk_o = 1'b0;
    endtask : edge_out

    // Free edges so the link side sees its reset
    task automatic idle(input int n);
        repeat (n) edge_out(1'b1, ~sdata_o);
    endtask : idle

    // I2S frame, left while LR low, MSB one clock after the LR change
    task automatic send_frame(input logic [31:0] lw [4], input logic [31:0] rw [4],
                              input int nb, input int half);
        logic [3:0] d;
        for (int i = 0; i < 2 * half; i++) begin
            // Unused slots toggle so a stale bit is never mistaken for data
            d = ~sdata_o;
            for (int c = 0; c < 4; c++) begin
                if (i >= 1 && i <= nb) d[c] = lw[c][nb - i];
                else if (i > half && i <= half + nb) d[c] = rw[c][half + nb - i];
            end
            edge_out(i >= half, d);
        end
    endtask : send_frame
endmodule : dird_audio_src

//--- test/dird_dac_input_ctrl_tb.sv
`timescale 1ns/1ns
module dird_dac_input_ctrl_tb;
    // Clock, reset and register port
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic [6:0] reg_addr = 7'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    // Converter side and status
    logic [3:0] pd = 4'h0;
    logic [3:0] mute = 4'h0;
    logic [191:0] dac_data;
    logic dac_valid;
    logic dac_ready = 1'b0;
    logic osr_64x;
    logic zero_flag;
    // Link lines from the source model
    logic bclk;
    logic lrclk;
    logic [3:0] sdata;
    // Words per input and the settings the device should hold
    logic [31:0] lw [4];
    logic [31:0] rw [4];
    logic [7:0] rt = 8'hE4;
    logic [3:0] mx = 4'h9;
    int miscompares = 0;
    int compares = 0;

    always #50 clk = ~clk;

    dird_dac_input_ctrl dird_dac_input_ctrl_inst (.REF_CLK_I(clk), .RESET_N_I(rst_n),
        .BCLK_I(bclk), .LRCLK_I(lrclk), .SERIAL_INPUT_I(sdata), .REG_WR_I(reg_wr),
        .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_RDATA_O(reg_rdata),
        .CONV_POWER_DOWN_I(pd), .CONV_MUTE_BIT_I(mute), .DAC_DATA_O(dac_data),
        .DAC_VALID_O(dac_valid), .DAC_READY_I(dac_ready), .OSR_64X_O(osr_64x),
        .ZERO_FLAG_O(zero_flag));
    dird_audio_src dird_audio_src_inst (.bclk_o(bclk), .lrclk_o(lrclk), .sdata_o(sdata));

    // Inputs always move 1 ns after the rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input logic [199:0] got, input logic [199:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask : chk

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        tick(1);
        reg_wr = 1'b0;
        // Let an edge pass so a following write never re-raises the strobe in this step
        tick(1);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        reg_addr = a;
        tick(1);
        chk(reg_rdata, e, "register read");
    endtask : rd

    task automatic load(input logic [31:0] a, input logic [31:0] b);
        for (int c = 0; c < 4; c++) begin
            lw[c] = a + c * 32'h0102_0305;
            rw[c] = b - c * 32'h0030_4007;
        end
    endtask : load

    // Word of nb bits placed in the 24-bit path: pad or drop low bits
    function automatic logic [23:0] samp(input logic [31:0] w, input int nb);
        logic [55:0] t;
        t = {w, 24'h000000} >> nb;
        return t[23:0];
    endfunction : samp

    function automatic logic [23:0] mix1(input logic [1:0] c, input logic [23:0] l,
                                         input logic [23:0] r);
        logic [24:0] s;
        s = {l[23], l} + {r[23], r};
        case (c)
            2'h0: return 24'h000000;
            2'h1: return l;
            2'h2: return r;
            default: return s[24:1];
        endcase
    endfunction : mix1

    function automatic logic [191:0] expect_frame(input int nb);
        logic [191:0] f;
        logic [1:0] s;
        for (int d = 0; d < 4; d++) begin
            s = rt[2*d +: 2];
            f[48*d +: 24] = mix1(mx[1:0], samp(lw[s], nb), samp(rw[s], nb));
            f[48*d+24 +: 24] = mix1(mx[3:2], samp(lw[s], nb), samp(rw[s], nb));
        end
        return f;
    endfunction : expect_frame

    // Wait for a frame, judge it, then take it
    task automatic take(input int nb, input string what);
        int n;
        n = 0;
        tick(1);
        while (dac_valid !== 1'b1 && n < 60) begin
            tick(1);
            n++;
        end
        chk({dac_valid, dac_data}, {1'b1, expect_frame(nb)}, what);
        dac_ready = 1'b1;
        tick(1);
        dac_ready = 1'b0;
    endtask : take

    task automatic test_reset();
        rd(7'h0C, 8'h0A);
        rd(7'h0F, 8'hE4);
        rd(7'h10, 8'h09);
        rd(7'h11, 8'h00);
        chk({osr_64x, zero_flag, dac_valid}, 3'b000, "outputs after reset");
        $display("test reset done");
    endtask : test_reset

    task automatic test_route_mix();
        logic [3:0] codes [4] = '{4'h0, 4'h6, 4'hF, 4'h9};
        rt = 8'h1B;
        wr(7'h0F, rt);
        for (int k = 0; k < 4; k++) begin
            mx = codes[k];
            wr(7'h10, {4'h0, mx});
            load(32'h0080_0003 + k, 32'h00FF_FFF0 - k);
            dird_audio_src_inst.send_frame(lw, rw, 24, 32);
            take(24, "route and mix");
        end
        rt = 8'hE4;
        wr(7'h0F, rt);
        $display("test route and mix done");
    endtask : test_route_mix

    task automatic test_word_len();
        int nb;
        wr(7'h0C, 8'h4A);
        tick(2);
        chk(osr_64x, 1'b1, "64x select");
        load(32'h8123_4567, 32'h7654_3219);
        for (int k = 0; k < 3; k++) begin
            nb = (k == 2) ? 32 : 16 + 4 * k;
            wr(7'h0C, {4'h0, (k == 2) ? 2'h3 : 2'(k), 2'h2});
            dird_audio_src_inst.send_frame(lw, rw, nb, (nb > 24) ? 40 : 32);
            take(nb, "word length");
        end
        wr(7'h0C, 8'h0A);
        tick(2);
        chk(osr_64x, 1'b0, "128x select");
        $display("test word length done");
    endtask : test_word_len

    task automatic test_flag_src();
        logic [3:0] f;
        for (int p = 0; p < 2; p++) begin
            pd = p ? 4'h1 : 4'h5;
            mute = p ? 4'h0 : 4'hA;
            f = pd | mute;
            for (int c = 0; c < 8; c++) begin
                wr(7'h10, {1'b0, 3'(c), 4'h9});
                tick(3);
                chk(zero_flag, c == 0 ? &f : c < 5 ? f[c-1] : 1'b0, "flag");
            end
        end
        pd = 4'h0;
        mute = 4'h0;
        wr(7'h10, 8'h09);
        $display("test flag source done");
    endtask : test_flag_src

    task automatic test_zero();
        load(32'h0, 32'h0);
        for (int c = 0; c < 4; c++) rw[c] = 32'h0;
        wr(7'h10, 8'h99);
        dac_ready = 1'b1;
        repeat (1023) dird_audio_src_inst.send_frame(lw, rw, 24, 32);
        tick(20);
        chk(zero_flag, 1'b0, "flag after 1023 zeros");
        dird_audio_src_inst.send_frame(lw, rw, 24, 32);
        tick(20);
        chk(zero_flag, 1'b1, "flag after 1024 zeros");
        dac_ready = 1'b0;
        lw[0] = 32'h0000_0001;
        dird_audio_src_inst.send_frame(lw, rw, 24, 32);
        take(24, "unmute");
        tick(2);
        chk(zero_flag, 1'b0, "flag cleared");
        wr(7'h10, 8'h09);
        $display("test zero detect done");
    endtask : test_zero

    // Output register, eight FIFO words and the holding frame fill; the last is lost
    task automatic test_fifo();
        for (int k = 0; k < 11; k++) begin
            load(32'h10 * k, 32'h0020_0000 + k);
            dird_audio_src_inst.send_frame(lw, rw, 24, 32);
        end
        for (int k = 0; k < 10; k++) begin
            load(32'h10 * k, 32'h0020_0000 + k);
            // Free link edges carry the read pointer over so the held frame can enter
            dird_audio_src_inst.idle(4);
            take(24, "buffered frame");
        end
        tick(40);
        chk(dac_valid, 1'b0, "dropped frame");
        $display("test buffer done");
    endtask : test_fifo

    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    // Main sequence; link edges during reset let the link side reset too
    initial begin
        dird_audio_src_inst.idle(8);
        tick(8);
        rst_n = 1'b1;
        dird_audio_src_inst.idle(4);
        tick(1);
        test_reset();
        test_route_mix();
        test_word_len();
        test_flag_src();
        test_zero();
        test_fifo();
        complete_run();
    end

    // Zero run is about 2.1 ms; anything past 5 ms is a hang
    initial begin
        #5000000;
        miscompares++;
        $display("MISMATCH at %0t: watchdog", $time);
        complete_run();
    end
endmodule : dird_dac_input_ctrl_tb
